// file: hdl/mes_status_regs.sv
// mes_status_regs: read-only bank that mirrors the sensorless estimator's
// internal variables onto an Avalon-MM slave with waitrequest.
// assumes i_status comes from logic on i_mclk; no pin inputs.
`default_nettype none

module mes_status_regs
  import mes_pkg::*;
(
  input  wire logic         i_mclk,   // 10 MHz system clock
  input  wire logic         i_rst,    // synchronous reset, high
  input  wire mes_status_t  i_status, // live estimator values
  input  wire mes_avm_req_t i_avm,    // avalon request
  output var  mes_avm_rsp_t o_avm     // avalon answer
);

  // ==========================================================
  // state
  typedef struct packed {
    mes_phase_t        phase;
    logic [AVM_DW-1:0] rdata;
    logic [1:0]        resp;
    mes_status_t       mirror;
  } mes_state_t;

  mes_state_t st_q;
  mes_state_t st_d;

  logic [IDX_W-1:0]  idx;
  logic              aligned;
  logic              req;
  logic              hit;
  logic [AVM_DW-1:0] sel;

  assign idx     = i_avm.address[AVM_AW-1:LANE_W];
  assign aligned = (i_avm.address[LANE_W-1:0] == LANE_ALIGNED);
  assign req     = (i_avm.read | i_avm.write) & (st_q.phase == PH_IDLE);

  // ==========================================================
  // read decode
  always_comb begin
    hit = aligned;
    sel = RESET_VALUE;
    case (idx)
      IDX_RESYNC_SPEED: begin
        sel = st_q.mirror.resync_speed_value;
      end
      IDX_POS_STEP: begin
        // upper half reserved, reads zero
        sel = {{(AVM_DW-STEP_FW){1'b0}},
               {(STEP_FW-STEP_W){1'b0}},
               st_q.mirror.position_detect_step};
      end
      IDX_POS_ANGLE: begin
        sel = st_q.mirror.position_detect_angle;
      end
      IDX_BEMF_D: begin
        sel = st_q.mirror.direct_axis_bemf;
      end
      IDX_BEMF_Q: begin
        sel = st_q.mirror.quadrature_axis_bemf;
      end
      IDX_ROTOR_SPEED: begin
        sel = st_q.mirror.estimated_rotor_speed;
      end
      IDX_ROTOR_ANGLE: begin
        sel = st_q.mirror.estimated_rotor_angle;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!aligned) begin
      sel = RESET_VALUE;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    // mirror follows the estimator only; no bus path reaches it
    st_d.mirror = i_status;
    case (st_q.phase)
      PH_IDLE: begin
        if (req) begin
          st_d.phase = PH_ANSWER;
          // a write stores nothing; it only gets its answer
          st_d.rdata = i_avm.read ? sel : RESET_VALUE;
          st_d.resp  = hit ? RESP_OKAY : RESP_DECERR;
        end
      end
      PH_ANSWER: begin
        st_d.phase = PH_IDLE;
      end
      default: begin
        st_d.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q.phase  <= PH_IDLE;
      st_q.rdata  <= RESET_VALUE;
      st_q.resp   <= RESP_OKAY;
      st_q.mirror <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  // one wait cycle: a fresh request always sees waitrequest high first
  always_comb begin
    o_avm.readdata    = st_q.rdata;
    o_avm.waitrequest = (st_q.phase != PH_ANSWER);
    o_avm.response    = st_q.resp;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  logic rd_at;
  assign rd_at = req & i_avm.read & aligned;

  a_resync_read: assert property (
    rd_at && idx == IDX_RESYNC_SPEED |=>
      !o_avm.waitrequest &&
      o_avm.readdata == $past(i_status.resync_speed_value, 2))
    else $error("resync speed read mismatch");

  a_step_reserved: assert property (
    rd_at && idx == IDX_POS_STEP |=>
      o_avm.readdata[AVM_DW-1:STEP_FW] == '0 && o_avm.response == RESP_OKAY)
    else $error("step reserved bits not zero");

  a_step_code: assert property (
    rd_at && idx == IDX_POS_STEP |=>
      o_avm.readdata[STEP_FW-1:0] ==
      {{(STEP_FW-STEP_W){1'b0}}, $past(i_status.position_detect_step, 2)})
    else $error("step code mismatch");

  a_pos_angle: assert property (
    rd_at && idx == IDX_POS_ANGLE |=>
      o_avm.readdata == $past(i_status.position_detect_angle, 2))
    else $error("initial angle read mismatch");

  a_bemf_direct: assert property (
    rd_at && idx == IDX_BEMF_D |=>
      o_avm.readdata == $past(i_status.direct_axis_bemf, 2))
    else $error("direct bemf read mismatch");

  a_bemf_quad: assert property (
    rd_at && idx == IDX_BEMF_Q |=>
      o_avm.readdata == $past(i_status.quadrature_axis_bemf, 2))
    else $error("quadrature bemf read mismatch");

  a_rotor_speed: assert property (
    rd_at && idx == IDX_ROTOR_SPEED |=>
      o_avm.readdata == $past(i_status.estimated_rotor_speed, 2))
    else $error("rotor speed read mismatch");

  a_rotor_angle: assert property (
    rd_at && idx == IDX_ROTOR_ANGLE |=>
      o_avm.readdata == $past(i_status.estimated_rotor_angle, 2))
    else $error("rotor angle read mismatch");

  a_write_ignored: assert property (
    req && i_avm.write |=>
      !o_avm.waitrequest && st_q.mirror == $past(i_status) ##1
      o_avm.waitrequest)
    else $error("write disturbed bank");

  a_unmapped_read: assert property (
    req && i_avm.read && !hit |=>
      o_avm.response == RESP_DECERR && o_avm.readdata == '0)
    else $error("unmapped read not refused");

  // ==========================================================
  // handshake checks: one wait cycle, then one answer cycle
  logic wr_at;
  logic miss_at;
  assign wr_at   = req & i_avm.write;
  assign miss_at = req & ~hit;

  a_take_waits: assert property (
    req |->
      o_avm.waitrequest)
    else $error("request taken without a wait cycle");

  a_answer_next: assert property (
    req |=>
      !o_avm.waitrequest)
    else $error("answer not in the cycle after the take");

  a_answer_once: assert property (
    !o_avm.waitrequest |=>
      o_avm.waitrequest)
    else $error("answer stood longer than one cycle");

  a_answer_owed: assert property (
    !o_avm.waitrequest |->
      $past(req))
    else $error("answer without a taken request");

  a_idle_quiet: assert property (
    o_avm.waitrequest && !req |=>
      o_avm.waitrequest)
    else $error("answer appeared while idle");

  a_no_take_busy: assert property (
    !o_avm.waitrequest |->
      !req)
    else $error("request taken during an answer");

  a_refused_once: assert property (
    miss_at |=>
      !o_avm.waitrequest ##1 o_avm.waitrequest)
    else $error("refused request answer timing wrong");

  a_resp_legal: assert property (
    !o_avm.waitrequest |->
      o_avm.response == RESP_OKAY ||
      o_avm.response == RESP_DECERR)
    else $error("answer carries a reserved response code");

  // ==========================================================
  // answer codes; a refusal never hides a mapped word
  // software may poll any location, so refusals carry zero data
  a_read_okay: assert property (
    rd_at && hit |=>
      o_avm.response == RESP_OKAY)
    else $error("mapped read not answered okay");

  a_write_okay: assert property (
    wr_at && hit |=>
      o_avm.response == RESP_OKAY &&
      o_avm.readdata == '0)
    else $error("mapped write answer wrong");

  a_write_refused: assert property (
    wr_at && !hit |=>
      o_avm.response == RESP_DECERR &&
      o_avm.readdata == '0)
    else $error("unmapped write not refused");

  a_lane_refused: assert property (
    req && !aligned |=>
      o_avm.response == RESP_DECERR &&
      o_avm.readdata == '0)
    else $error("misaligned access not refused");

  a_decerr_only_miss: assert property (
    !o_avm.waitrequest && o_avm.response == RESP_DECERR |->
      $past(miss_at))
    else $error("mapped access refused");

  a_okay_only_hit: assert property (
    !o_avm.waitrequest && o_avm.response == RESP_OKAY |->
      $past(req && hit))
    else $error("unmapped access answered okay");

  a_step_pad: assert property (
    rd_at && idx == IDX_POS_STEP |=>
      o_avm.readdata[STEP_FW-1:STEP_W] == '0)
    else $error("step code padding not zero");

  // ==========================================================
  // reset and mirror: the bank reads zero until the estimator speaks
  // mirror lags the estimator by one cycle to keep the read path short
  a_reset_clean: assert property (
    $fell(i_rst) |->
      o_avm.waitrequest &&
      o_avm.readdata == RESET_VALUE &&
      o_avm.response == RESP_OKAY &&
      st_q.mirror == '0)
    else $error("bank not clean after reset");

  a_mirror_follows: assert property (
    !$past(i_rst) |->
      st_q.mirror == $past(i_status))
    else $error("mirror strayed from estimator");

endmodule
`default_nettype wire

// file: include/mes_pkg.sv
// mes_pkg: constants and carrier types of the estimator status bank.
// assumes one 10 MHz clock and an Avalon-MM slave port with byte addressing.
`default_nettype none
package mes_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned AVM_AW = 13;
  localparam int unsigned AVM_DW = 32;
  localparam int unsigned IDX_W  = 11;
  localparam int unsigned LANE_W = 2;

  // ==========================================================
  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RESYNC_SPEED = 11'h684;
  localparam logic [IDX_W-1:0] IDX_POS_STEP     = 11'h6b8;
  localparam logic [IDX_W-1:0] IDX_POS_ANGLE    = 11'h6fc;
  localparam logic [IDX_W-1:0] IDX_BEMF_D       = 11'h742;
  localparam logic [IDX_W-1:0] IDX_BEMF_Q       = 11'h744;
  localparam logic [IDX_W-1:0] IDX_ROTOR_SPEED  = 11'h752;
  localparam logic [IDX_W-1:0] IDX_ROTOR_ANGLE  = 11'h756;

  // ==========================================================
  // field layout and reset values
  localparam int unsigned FRAC_BITS = 27;
  localparam int unsigned STEP_W    = 4;
  localparam int unsigned STEP_FW   = 16;
  localparam logic [AVM_DW-1:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [LANE_W-1:0] LANE_ALIGNED = 2'h0;

  // ==========================================================
  // avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================
  // position detect step codes
  typedef enum logic [STEP_W-1:0] {
    STEP_INIT            = 4'h0,
    STEP_VECTOR_SETUP    = 4'h1,
    STEP_RUN             = 4'h2,
    STEP_SLOW_RISE_TIMING = 4'h3,
    STEP_SLOW_FALL_TIMING = 4'h4,
    STEP_WAIT_DECAY      = 4'h5,
    STEP_COLLECT_TIMES   = 4'h6,
    STEP_NEXT_VECTOR     = 4'h7,
    STEP_SECTOR_CALC     = 4'h8,
    STEP_POSITION_CALC   = 4'h9,
    STEP_ANGLE_CALC      = 4'ha,
    STEP_DONE            = 4'hb,
    STEP_ERROR           = 4'hc
  } mes_step_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [AVM_DW-1:0] resync_speed_value;
    mes_step_t         position_detect_step;
    logic [AVM_DW-1:0] position_detect_angle;
    logic [AVM_DW-1:0] direct_axis_bemf;
    logic [AVM_DW-1:0] quadrature_axis_bemf;
    logic [AVM_DW-1:0] estimated_rotor_speed;
    logic [AVM_DW-1:0] estimated_rotor_angle;
  } mes_status_t;

  typedef struct packed {
    logic [AVM_AW-1:0]   address;
    logic                read;
    logic                write;
    logic [AVM_DW-1:0]   writedata;
    logic [AVM_DW/8-1:0] byteenable;
  } mes_avm_req_t;

  typedef struct packed {
    logic [AVM_DW-1:0] readdata;
    logic              waitrequest;
    logic [1:0]        response;
  } mes_avm_rsp_t;

  typedef enum logic {
    PH_IDLE,
    PH_ANSWER
  } mes_phase_t;

endpackage
`default_nettype wire

// file: test/test_motor_estimator_status_regs.sv
// test_motor_estimator_status_regs: self-checking bench for the status bank.
// assumes the bank's avalon answer timing as handed over; bench drives all ports.
`default_nettype none
module test_motor_estimator_status_regs import mes_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic         i_mclk;
  logic         i_rst;
  mes_status_t  st;
  mes_avm_req_t req;
  mes_avm_rsp_t rsp;
  logic [31:0]  rdat;
  logic [1:0]   rres;
  int           mismatches = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  logic [10:0]  ix [7] = '{IDX_RESYNC_SPEED, IDX_POS_STEP, IDX_POS_ANGLE, IDX_BEMF_D,
                           IDX_BEMF_Q, IDX_ROTOR_SPEED, IDX_ROTOR_ANGLE};

  mes_status_regs dut (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_status (st),
    .i_avm    (req),
    .o_avm    (rsp)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // a whole run is under two hundred cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until waitrequest is low at a rising edge; answer taken at that edge
  // rsp is read before that edge's own updates land, so it is the sampled value
  task automatic bus(input logic [10:0] i, input logic [1:0] lane, input logic wr);
    @(posedge i_mclk);
    req.address    <= {i, lane};
    req.read       <= !wr;
    req.write      <= wr;
    req.writedata  <= 32'hffff_ffff;
    req.byteenable <= 4'hf;
    @(posedge i_mclk);
    while (rsp.waitrequest !== 1'b0) @(posedge i_mclk);
    rdat = rsp.readdata;
    rres = rsp.response;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_values(input bit wr_first);
    logic [31:0] v [7];
    v = '{32'h8000_0001, 32'h0000_000b, 32'h7fff_ffff, 32'h0800_0000,
          32'hf000_000f, 32'h1234_5678, 32'hedcb_a987};
    @(posedge i_mclk);
    st <= '{v[0], mes_step_t'(v[1][3:0]), v[2], v[3], v[4], v[5], v[6]};
    repeat (3) @(posedge i_mclk);
    for (int k = 0; k < 7 && wr_first; k++) begin
      bus(ix[k], 2'h0, 1'b1);
      chk("write response", {30'h0, rres}, {30'h0, RESP_OKAY});
    end
    for (int k = 0; k < 7; k++) begin
      bus(ix[k], 2'h0, 1'b0);
      chk("status word", rdat, v[k]);
      chk("read response", {30'h0, rres}, {30'h0, RESP_OKAY});
    end
    $display("done values write_first=%0d", wr_first);
  endtask

  task automatic t_steps;
    for (int k = 0; k < 13; k++) begin
      @(posedge i_mclk);
      st.position_detect_step <= mes_step_t'(k[3:0]);
      repeat (2) @(posedge i_mclk);
      bus(IDX_POS_STEP, 2'h0, 1'b0);
      chk("step word", rdat, {28'h0, k[3:0]});
    end
    $display("done steps");
  endtask

  task automatic t_unmapped;
    bus(11'h001, 2'h0, 1'b0);
    chk("unmapped data", rdat, 32'h0);
    chk("unmapped response", {30'h0, rres}, {30'h0, RESP_DECERR});
    bus(IDX_RESYNC_SPEED, 2'h1, 1'b0);
    chk("misaligned data", rdat, 32'h0);
    chk("misaligned response", {30'h0, rres}, {30'h0, RESP_DECERR});
    bus(11'h001, 2'h0, 1'b1);
    chk("unmapped write response", {30'h0, rres}, {30'h0, RESP_DECERR});
    $display("done unmapped");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    i_rst = 1'b1;
    st    = '0;
    req   = '0;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    chk("idle waitrequest", {31'h0, rsp.waitrequest}, 32'h1);
    bus(IDX_ROTOR_ANGLE, 2'h0, 1'b0);
    chk("reset value", rdat, RESET_VALUE);
    t_values(1'b0);
    t_steps();
    t_values(1'b1);
    t_unmapped();
    final_report();
  end
endmodule
`default_nettype wire
